// >>> src/cwsd_pkg.sv
package cwsd_pkg;

    localparam int unsigned AW = 24;
    localparam int unsigned DW = 32;
    localparam int unsigned WW = 24;

    // Register port byte addresses
    localparam logic [AW-1:0] A_DEV_OPT = 24'h002bac;
    localparam logic [AW-1:0] A_ALT_CTX = 24'h002bb0;
    localparam logic [AW-1:0] A_BOOT_SEQ = 24'h002bfc;
    localparam logic [AW-1:0] A_BOOT_MODE = 24'h801000;
    localparam logic [AW-1:0] A_STATUS = 24'h002c00;
    localparam logic [AW-1:0] A_CTRL = 24'h002c04;
    localparam logic [AW-1:0] A_PWM_KEY = 24'h002c08;

    // Flash addresses of the configuration words, partition A
    localparam logic [AW-1:0] F_SEC = 24'h00af80;
    localparam logic [AW-1:0] F_LIM = 24'h00af90;
    localparam logic [AW-1:0] F_OSC = 24'h00af98;
    localparam logic [AW-1:0] F_ICD = 24'h00afa8;
    localparam logic [AW-1:0] F_OPT = 24'h00afac;
    localparam logic [AW-1:0] F_ALT = 24'h00afb0;
    localparam logic [AW-1:0] F_SEQ = 24'h00affc;
    localparam logic [AW-1:0] F_BOOT = 24'h801000;
    localparam logic [AW-1:0] F_PART_B_OFS = 24'h400000;
    localparam logic [AW-1:0] F_CFG_LO = 24'h00af80;
    localparam logic [AW-1:0] F_CFG_HI = 24'h00afff;

    // Shadow word indices
    localparam logic [2:0] IX_SEC = 3'h0;
    localparam logic [2:0] IX_LIM = 3'h1;
    localparam logic [2:0] IX_OSC = 3'h2;
    localparam logic [2:0] IX_ICD = 3'h3;
    localparam logic [2:0] IX_OPT = 3'h4;
    localparam logic [2:0] IX_ALT = 3'h5;
    localparam logic [2:0] IX_SEQ = 3'h6;
    localparam logic [2:0] IX_BOOT = 3'h7;
    localparam logic [2:0] IX_LAST_CFG = 3'h5;

    // Field positions
    localparam int unsigned B_BOOT_WR = 0;
    localparam int unsigned B_BOOT_LVL = 1;
    localparam int unsigned B_BOOT_ABS = 3;
    localparam int unsigned B_GEN_WR = 5;
    localparam int unsigned B_GEN_LVL = 6;
    localparam int unsigned B_CFG_WR = 8;
    localparam int unsigned B_CFG_LVL = 9;
    localparam int unsigned B_AIVT = 15;
    localparam int unsigned B_SWPDIS = 15;
    localparam int unsigned B_TWO_SPEED = 7;
    localparam int unsigned B_PWM_LOCK = 0;
    localparam int unsigned B_SEQ_NUM = 0;
    localparam int unsigned B_SEQ_INV = 12;
    localparam int unsigned W_SEQ = 12;
    localparam int unsigned W_LIM = 13;
    localparam logic [1:0] MODE_SINGLE = 2'h3;

    localparam logic [1:0] CTRL_IVT = 2'h1;
    localparam logic [WW-1:0] KEY_ONE = 24'h0000ab;
    localparam logic [WW-1:0] KEY_TWO = 24'h0000cd;

    typedef enum logic [1:0] {
        LVL_NONE = 2'h0,
        LVL_STD = 2'h1,
        LVL_ENH = 2'h2,
        LVL_HIGH = 2'h3
    } cwsd_lvl_e;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_MODE = 6'h02,
        S_SEQA = 6'h04,
        S_SEQB = 6'h08,
        S_CFG = 6'h10,
        S_DONE = 6'h20
    } cwsd_state_e;

    function automatic cwsd_lvl_e cwsd_lvl2(input logic [1:0] f);
        if (f == 2'h3) begin
            return LVL_NONE;
        end else if (f == 2'h2) begin
            return LVL_STD;
        end
        return LVL_HIGH;
    endfunction

endpackage

// >>> src/cwsd_field_decode.sv
`timescale 1ns/1ns
`default_nettype none
module cwsd_field_decode
    import cwsd_pkg::*;
(
    input wire logic [WW-1:0] sec_word,
    input wire logic [WW-1:0] lim_word,
    input wire logic [WW-1:0] osc_word,
    input wire logic [WW-1:0] icd_word,
    input wire logic [WW-1:0] opt_word,
    output logic boot_seg_present,
    output logic boot_seg_write_allow,
    output cwsd_lvl_e boot_seg_protect_level,
    output logic [W_LIM-1:0] boot_seg_last_page,
    output cwsd_lvl_e general_seg_protect_level,
    output logic general_seg_write_allow,
    output cwsd_lvl_e config_seg_protect_level,
    output logic config_seg_write_allow,
    output logic swap_allowed,
    output logic alt_vector_table_disable,
    output logic two_speed_startup_enable,
    output logic pwm_write_lock
);
    wire logic [2:0] cfg_lvl_bits = sec_word[B_CFG_LVL+:3];

    assign boot_seg_present = ~sec_word[B_BOOT_ABS];
    assign boot_seg_write_allow = sec_word[B_BOOT_WR];
    assign boot_seg_protect_level =
        cwsd_lvl2(sec_word[B_BOOT_LVL+:2]);
    // Stored inverted so that clearing more bits grows the segment
    assign boot_seg_last_page = ~lim_word[W_LIM-1:0];
    assign general_seg_protect_level =
        cwsd_lvl2(sec_word[B_GEN_LVL+:2]);
    assign general_seg_write_allow = sec_word[B_GEN_WR];
    assign config_seg_write_allow = sec_word[B_CFG_WR];
    assign config_seg_protect_level =
        !cfg_lvl_bits[2] ? LVL_HIGH :
        !cfg_lvl_bits[1] ? LVL_ENH :
        !cfg_lvl_bits[0] ? LVL_STD : LVL_NONE;
    assign swap_allowed = ~icd_word[B_SWPDIS];
    assign alt_vector_table_disable = sec_word[B_AIVT];
    assign two_speed_startup_enable = osc_word[B_TWO_SPEED];
    assign pwm_write_lock = opt_word[B_PWM_LOCK];
endmodule
`default_nettype wire

// >>> src/cwsd_config_loader.sv
// Functional notes
// - Load configuration only from active partition
// - Soft swap keeps current configuration
// - Boot segment protect level decode
// - Boot enable bit one means no segment
// - Boot write-protect bit zero blocks writes
// - Boot limit holds inverted last page
// - General segment protect level decode
// - General write-protect bit zero protects memory
// - Config write-protect bit zero protects config
// - Config segment three-bit protect decode
// - Swap instruction only when its bit zero
// - Lower valid sequence number picks partition
// - Sequence invalid unless inverse is complement
// - Alternate vectors need bit zero and control
// - Two-speed start-up on fast RC first
// - PWM lock needs key sequence to write
// - Reload all shadow words on every reset; the sequence word is not reloaded in single-partition mode
// - Fetch from config space forces reset
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module cwsd_config_loader (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [cwsd_pkg::AW-1:0] reg_addr,
    input wire logic [cwsd_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cwsd_pkg::DW-1:0] reg_rdata_q,
    output logic flash_rd_q,
    output logic [cwsd_pkg::AW-1:0] flash_addr_q,
    input wire logic [cwsd_pkg::WW-1:0] flash_rdata,
    input wire logic swap_exec,
    input wire logic fetch_valid,
    input wire logic [cwsd_pkg::AW-1:0] fetch_addr,
    input wire logic pwm_reg_write,
    output logic config_ready_q,
    output logic active_partition_q,
    output logic boot_seg_present_q,
    output logic boot_seg_write_allow_q,
    output cwsd_pkg::cwsd_lvl_e boot_seg_protect_level_q,
    output logic [cwsd_pkg::W_LIM-1:0] boot_seg_last_page_q,
    output cwsd_pkg::cwsd_lvl_e general_seg_protect_level_q,
    output logic general_seg_write_allow_q,
    output cwsd_pkg::cwsd_lvl_e config_seg_protect_level_q,
    output logic config_seg_write_allow_q,
    output logic swap_allowed_q,
    output logic alt_vector_table_on_q,
    output logic two_speed_startup_q,
    output logic pwm_write_lock_q,
    output logic pwm_write_ok_q,
    output logic fetch_reset_req_q
);
    import cwsd_pkg::*;

    // ========================================================
    // Load sequencer
    cwsd_state_e state_q, state_d;
    logic wait_q;
    logic [2:0] idx_q;
    logic [WW-1:0] cfg_q [0:7];
    logic [WW-1:0] seq_a_q;
    logic part_sel_q;

    function automatic logic [AW-1:0] cfg_addr(input logic [2:0] ix);
        case (ix)
            IX_SEC: return F_SEC;
            IX_LIM: return F_LIM;
            IX_OSC: return F_OSC;
            IX_ICD: return F_ICD;
            IX_OPT: return F_OPT;
            default: return F_ALT;
        endcase
    endfunction

    function automatic logic seq_ok(input logic [WW-1:0] w);
        return w[B_SEQ_NUM+:W_SEQ] == ~w[B_SEQ_INV+:W_SEQ];
    endfunction

    wire logic [AW-1:0] part_base = part_sel_q ? F_PART_B_OFS : '0;
    wire logic dual_mode = cfg_q[IX_BOOT][1:0] != MODE_SINGLE;
    wire logic a_ok = seq_ok(seq_a_q);
    wire logic b_ok = seq_ok(flash_rdata);
    // Invalid numbers lose; a tie or two invalid numbers keeps A
    wire logic pick_b = b_ok && (!a_ok ||
        flash_rdata[B_SEQ_NUM+:W_SEQ] <
        seq_a_q[B_SEQ_NUM+:W_SEQ]);
    wire logic last_cfg = idx_q == IX_LAST_CFG;
    wire logic cap = wait_q;
    wire logic dual_mode_next = flash_rdata[1:0] != MODE_SINGLE;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: state_d = S_MODE;
            S_MODE: if (cap) state_d = dual_mode_next ? S_SEQA : S_CFG;
            S_SEQA: if (cap) state_d = S_SEQB;
            S_SEQB: if (cap) state_d = S_CFG;
            S_CFG: if (cap && last_cfg) state_d = S_DONE;
            S_DONE: state_d = S_DONE;
        endcase
    end

    wire logic busy = state_q != S_IDLE && state_q != S_DONE;
    wire logic [AW-1:0] rd_addr =
        state_q == S_MODE ? F_BOOT :
        state_q == S_SEQA ? F_SEQ :
        state_q == S_SEQB ? F_SEQ + F_PART_B_OFS :
        part_base + cfg_addr(idx_q);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            wait_q <= 1'b0;
            flash_rd_q <= 1'b0;
            flash_addr_q <= '0;
        end else begin
            state_q <= state_d;
            wait_q <= busy && !wait_q;
            flash_rd_q <= busy && !wait_q && !flash_rd_q;
            flash_addr_q <= rd_addr;
        end
    end

    // Shadow words are cleared by reset and refilled by the sequencer, except the sequence word in single-partition mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                cfg_q[i] <= '0;
            end
            idx_q <= IX_SEC;
            seq_a_q <= '0;
            part_sel_q <= 1'b0;
        end else if (cap) begin
            unique case (state_q)
                S_MODE: cfg_q[IX_BOOT] <= flash_rdata;
                S_SEQA: begin
                    seq_a_q <= flash_rdata;
                    cfg_q[IX_SEQ] <= flash_rdata;
                end
                S_SEQB: begin
                    part_sel_q <= pick_b;
                    if (pick_b) cfg_q[IX_SEQ] <= flash_rdata;
                end
                S_CFG: begin
                    cfg_q[idx_q] <= flash_rdata;
                    idx_q <= idx_q + 3'h1;
                end
                default: ;
            endcase
        end
    end

    // ========================================================
    // Field decode, registered once when loading completes
    logic d_bs_present, d_bs_wr, d_gs_wr, d_cs_wr, d_swap_ok;
    logic d_aivt_dis, d_two_speed, d_pwm_lock;
    cwsd_lvl_e d_bs_lvl, d_gs_lvl, d_cs_lvl;
    logic [W_LIM-1:0] d_last_page;

    cwsd_field_decode u_dec (
        .sec_word(cfg_q[IX_SEC]),
        .lim_word(cfg_q[IX_LIM]),
        .osc_word(cfg_q[IX_OSC]),
        .icd_word(cfg_q[IX_ICD]),
        .opt_word(cfg_q[IX_OPT]),
        .boot_seg_present(d_bs_present),
        .boot_seg_write_allow(d_bs_wr),
        .boot_seg_protect_level(d_bs_lvl),
        .boot_seg_last_page(d_last_page),
        .general_seg_protect_level(d_gs_lvl),
        .general_seg_write_allow(d_gs_wr),
        .config_seg_protect_level(d_cs_lvl),
        .config_seg_write_allow(d_cs_wr),
        .swap_allowed(d_swap_ok),
        .alt_vector_table_disable(d_aivt_dis),
        .two_speed_startup_enable(d_two_speed),
        .pwm_write_lock(d_pwm_lock)
    );

    wire logic load_now = state_q == S_DONE && !config_ready_q;

    // Until loading ends everything reads fully protected
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            config_ready_q <= 1'b0;
            boot_seg_present_q <= 1'b0;
            boot_seg_write_allow_q <= 1'b0;
            boot_seg_protect_level_q <= LVL_HIGH;
            boot_seg_last_page_q <= '0;
            general_seg_protect_level_q <= LVL_HIGH;
            general_seg_write_allow_q <= 1'b0;
            config_seg_protect_level_q <= LVL_HIGH;
            config_seg_write_allow_q <= 1'b0;
            swap_allowed_q <= 1'b0;
            two_speed_startup_q <= 1'b0;
            pwm_write_lock_q <= 1'b1;
        end else if (load_now) begin
            config_ready_q <= 1'b1;
            boot_seg_present_q <= d_bs_present;
            boot_seg_write_allow_q <= d_bs_wr;
            boot_seg_protect_level_q <= d_bs_lvl;
            boot_seg_last_page_q <= d_last_page;
            general_seg_protect_level_q <= d_gs_lvl;
            general_seg_write_allow_q <= d_gs_wr;
            config_seg_protect_level_q <= d_cs_lvl;
            config_seg_write_allow_q <= d_cs_wr;
            swap_allowed_q <= d_swap_ok;
            two_speed_startup_q <= d_two_speed;
            pwm_write_lock_q <= d_pwm_lock;
        end
    end

    // ========================================================
    // Soft swap: the partition flag flips, shadow words do not
    wire logic swap_take = swap_exec && config_ready_q &&
                           swap_allowed_q && dual_mode;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            active_partition_q <= 1'b0;
        end else if (load_now) begin
            active_partition_q <= part_sel_q;
        end else if (swap_take) begin
            active_partition_q <= ~active_partition_q;
        end
    end

    // ========================================================
    // Software control, alternate vectors and PWM key
    logic ivt_sel_q, key_armed_q, unlocked_q;
    wire logic wr_ctrl = reg_wr && reg_addr == A_CTRL;
    wire logic wr_key = reg_wr && reg_addr == A_PWM_KEY;
    wire logic key1 = wr_key && reg_wdata[WW-1:0] == KEY_ONE;
    wire logic key2 = wr_key && reg_wdata[WW-1:0] == KEY_TWO;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ivt_sel_q <= 1'b0;
            key_armed_q <= 1'b0;
            unlocked_q <= 1'b0;
        end else begin
            if (wr_ctrl) ivt_sel_q <= reg_wdata[0];
            if (wr_key) key_armed_q <= key1;
            // One protected write per key pair; a new unlock wins
            if (key2 && key_armed_q) begin
                unlocked_q <= 1'b1;
            end else if (pwm_reg_write) begin
                unlocked_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alt_vector_table_on_q <= 1'b0;
            pwm_write_ok_q <= 1'b0;
        end else begin
            // The table also needs a boot segment to live in
            alt_vector_table_on_q <= config_ready_q && !d_aivt_dis &&
                boot_seg_present_q && ivt_sel_q;
            pwm_write_ok_q <= config_ready_q &&
                (!pwm_write_lock_q || unlocked_q);
        end
    end

    // ========================================================
    // Fetch guard
    wire logic fetch_in_cfg = fetch_valid &&
        ((fetch_addr >= F_CFG_LO && fetch_addr <= F_CFG_HI) ||
         fetch_addr == F_BOOT);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fetch_reset_req_q <= 1'b0;
        end else begin
            fetch_reset_req_q <= fetch_in_cfg;
        end
    end

    // ========================================================
    // Register read port
    wire logic [WW-1:0] status_word = {{(WW-3){1'b0}},
        unlocked_q, active_partition_q, config_ready_q};
    wire logic [WW-1:0] rd_mux =
        reg_addr == A_DEV_OPT ? cfg_q[IX_OPT] :
        reg_addr == A_ALT_CTX ? cfg_q[IX_ALT] :
        reg_addr == A_BOOT_SEQ ? cfg_q[IX_SEQ] :
        reg_addr == A_BOOT_MODE ? cfg_q[IX_BOOT] :
        reg_addr == A_STATUS ? status_word :
        reg_addr == A_CTRL ? {{(WW-1){1'b0}}, ivt_sel_q} : '0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= reg_rd ? {{(DW-WW){1'b0}}, rd_mux} : '0;
        end
    end

    // ========================================================
    // Checks
    a_outputs_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        config_ready_q && $past(config_ready_q) |->
        $stable(general_seg_write_allow_q) && $stable(boot_seg_last_page_q)
        && $stable(config_seg_protect_level_q))
        else $error("decoded outputs changed between resets");
    a_swap_keeps_cfg: assert property (@(posedge clk_sys) disable iff (!rst_n)
        swap_take |=> active_partition_q != $past(active_partition_q)
        && $stable(cfg_q[IX_SEC]) && $stable(pwm_write_lock_q))
        else $error("soft swap disturbed configuration");
    a_swap_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        config_ready_q && !swap_allowed_q && !load_now |=>
        $stable(active_partition_q))
        else $error("partition swapped while instruction disabled");
    a_boot_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        config_ready_q |-> boot_seg_write_allow_q == cfg_q[IX_SEC][B_BOOT_WR])
        else $error("boot write allow wrong");
    a_gen_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        config_ready_q |->
        general_seg_write_allow_q == cfg_q[IX_SEC][B_GEN_WR])
        else $error("general write allow wrong");
    a_cfg_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        config_ready_q |-> config_seg_write_allow_q == cfg_q[IX_SEC][B_CFG_WR])
        else $error("config write allow wrong");
    a_boot_absent: assert property (@(posedge clk_sys) disable iff (!rst_n)
        config_ready_q |-> boot_seg_present_q == !cfg_q[IX_SEC][B_BOOT_ABS])
        else $error("boot segment presence wrong");
    a_seq_choice: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == S_SEQB && cap |=> part_sel_q == $past(pick_b))
        else $error("partition choice wrong");
    a_fetch_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fetch_in_cfg |=> fetch_reset_req_q)
        else $error("config fetch gave no reset request");
    a_load_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == S_IDLE |-> ##[1:40] config_ready_q)
        else $error("configuration load too slow");
endmodule
`default_nettype wire

// >>> sim/cwsd_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================
// Configuration flash memory
// ==========================
module cwsd_flash_model (
    input wire logic clk_sys,
    input wire logic flash_rd_q,
    input wire logic [cwsd_pkg::AW-1:0] flash_addr_q,
    output logic [cwsd_pkg::WW-1:0] flash_rdata
);
    // Erased words read as all ones; the bench programs the rest
    logic [23:0] mem [logic [23:0]];
    logic [23:0] idle_q = 24'h5a5a5a;
    always @(posedge clk_sys) begin
        idle_q <= ~idle_q;
    end
    // The loader captures in the cycle of its request, so the array
    // answers at once; outside a read the bus churns
    always_comb begin
        if (flash_rd_q) begin
            flash_rdata = mem.exists(flash_addr_q) ? mem[flash_addr_q]
                : 24'hffffff;
        end else begin
            flash_rdata = idle_q;
        end
    end
endmodule
`default_nettype wire

// >>> sim/config_word_security_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
module config_word_security_decoder_tb;
    import cwsd_pkg::*;
    logic clk_sys, rst_n, reg_wr, reg_rd, swap_exec, fetch_valid;
    logic pwm_reg_write, flash_rd_q, config_ready_q, active_partition_q;
    logic [AW-1:0] reg_addr, fetch_addr, flash_addr_q;
    logic [DW-1:0] reg_wdata, reg_rdata_q;
    logic [WW-1:0] flash_rdata;
    logic boot_seg_present_q, boot_seg_write_allow_q, swap_allowed_q;
    logic general_seg_write_allow_q, config_seg_write_allow_q;
    logic alt_vector_table_on_q, two_speed_startup_q, pwm_write_lock_q;
    logic pwm_write_ok_q, fetch_reset_req_q;
    logic [W_LIM-1:0] boot_seg_last_page_q;
    cwsd_lvl_e boot_seg_protect_level_q, general_seg_protect_level_q;
    cwsd_lvl_e config_seg_protect_level_q;
    int num_errors = 0;
    int check_count = 0;
    // Every protect code of the boot and general fields appears once across the table; the config field gets codes 7, 6, 5 and 3
    logic [23:0] sec_t [4] = '{24'hff7ff7, 24'hfffc9c, 24'hff7b73, 24'hff7731};
    logic [23:0] lim_t [4] = '{24'hff1ffd, 24'hff0123, 24'hff1000, 24'hff0000};
    logic [AW-1:0] fa [5] = '{F_CFG_LO, F_CFG_HI, F_BOOT, 24'h00af7c,
        24'h00b000};

    cwsd_config_loader u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_q, .flash_rd_q, .flash_addr_q,
        .flash_rdata, .swap_exec, .fetch_valid, .fetch_addr, .pwm_reg_write,
        .config_ready_q, .active_partition_q, .boot_seg_present_q,
        .boot_seg_write_allow_q, .boot_seg_protect_level_q,
        .boot_seg_last_page_q, .general_seg_protect_level_q,
        .general_seg_write_allow_q, .config_seg_protect_level_q,
        .config_seg_write_allow_q, .swap_allowed_q, .alt_vector_table_on_q,
        .two_speed_startup_q, .pwm_write_lock_q, .pwm_write_ok_q,
        .fetch_reset_req_q);
    cwsd_flash_model u_flash (.clk_sys, .flash_rd_q, .flash_addr_q,
        .flash_rdata);

    // ==========
    // Helpers
    // ==========
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, exp, input string m);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    task automatic swap_pulse();
        @(posedge clk_sys);
        swap_exec <= 1'b1;
        @(posedge clk_sys);
        swap_exec <= 1'b0;
        tick(2);
    endtask
    task automatic do_reset(input int n);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        tick(n);
        chk(config_ready_q, 0, "ready in reset");
        chk(boot_seg_protect_level_q, LVL_HIGH, "level in reset");
        rst_n <= 1'b1;
        for (int i = 0; i < 60 && config_ready_q !== 1'b1; i++) begin
            tick(1);
        end
        // Registered options follow ready by one cycle
        tick(1);
        chk(config_ready_q, 1, "load done");
    endtask
    // Reserved-high and unused bits are programmed as ones
    task automatic prog(input logic [AW-1:0] o, input int c);
        u_flash.mem[F_SEC + o] = sec_t[c];
        u_flash.mem[F_LIM + o] = lim_t[c];
        u_flash.mem[F_OSC + o] = c[0] ? 24'hffffff : 24'hffff7f;
        u_flash.mem[F_ICD + o] = c[0] ? 24'hffffff : 24'hff7fff;
        u_flash.mem[F_OPT + o] = c[0] ? 24'hffffff : 24'hfffffe;
        u_flash.mem[F_ALT + o] = 24'hffff77 ^ 24'(c);
        u_flash.mem[24'h00af94 + o] = 24'hff7fff;
    endtask
    function automatic cwsd_lvl_e lv2(input logic [1:0] f);
        return (f == 2'h3) ? LVL_NONE : (f == 2'h2) ? LVL_STD : LVL_HIGH;
    endfunction
    function automatic cwsd_lvl_e lv3(input logic [2:0] f);
        return (f == 3'h7) ? LVL_NONE : (f == 3'h6) ? LVL_STD
            : f[2] ? LVL_ENH : LVL_HIGH;
    endfunction
    task automatic chk_cfg(input int c, input logic ivt);
        logic [23:0] s;
        s = sec_t[c];
        chk(boot_seg_write_allow_q, s[0], "bwa");
        chk(boot_seg_protect_level_q, lv2(s[2:1]), "bl");
        chk(boot_seg_present_q, !s[3], "bsp");
        chk(boot_seg_last_page_q, 13'(~lim_t[c][12:0]), "lim");
        chk(general_seg_write_allow_q, s[5], "gwa");
        chk(general_seg_protect_level_q, lv2(s[7:6]), "gl");
        chk(config_seg_write_allow_q, s[8], "cwa");
        chk(config_seg_protect_level_q, lv3(s[11:9]), "cl");
        chk(alt_vector_table_on_q, ivt & !(s[15]|s[3]), "av");
        chk(two_speed_startup_q, c[0], "ts");
        chk(pwm_write_lock_q, c[0], "lock");
        chk(swap_allowed_q, !c[0], "swp");
        chk(pwm_write_ok_q, !c[0], "pwm ok");
    endtask

    // ==========
    // Watchdog
    // ==========
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end

    // ==========
    // Tests
    // ==========
    initial begin
        logic [DW-1:0] d;
        rst_n = 1'b0;
        reg_addr = 24'h000000;
        reg_wdata = 32'h00000000;
        {reg_wr, reg_rd, swap_exec, fetch_valid, pwm_reg_write} = 5'h00;
        fetch_addr = 24'h000000;
        u_flash.mem[F_BOOT] = 24'hffffff;
        for (int c = 0; c < 4; c++) begin
            prog(24'h000000, c);
            do_reset(c == 0 ? 12 : 3);
            chk(active_partition_q, 0, "single part");
            chk_cfg(c, 1'b0);
            wr(A_CTRL, {30'h0, CTRL_IVT});
            tick(2);
            chk_cfg(c, 1'b1);
        end
        $display("test single_decode done");
        rd(A_STATUS, d);
        chk(d[1:0], 2'h1, "status");
        rd(A_DEV_OPT, d);
        chk(d, 32'h00ffffff, "opt word");
        wr(A_DEV_OPT, 32'h00000000);
        rd(A_DEV_OPT, d);
        chk(d, 32'h00ffffff, "opt read only");
        rd(A_ALT_CTX, d);
        chk(d, 32'h00ffff74, "alt word");
        rd(A_BOOT_MODE, d);
        chk(d, 32'h00ffffff, "mode word");
        rd(24'h002c10, d);
        chk(d, 32'h00000000, "unmapped");
        $display("test registers done");
        chk(pwm_write_ok_q, 0, "locked");
        wr(A_PWM_KEY, {8'h0, KEY_TWO});
        wr(A_PWM_KEY, {8'h0, KEY_ONE});
        tick(3);
        chk(pwm_write_ok_q, 0, "wrong order");
        wr(A_PWM_KEY, {8'h0, KEY_TWO});
        tick(3);
        chk(pwm_write_ok_q, 1, "unlocked");
        @(posedge clk_sys);
        pwm_reg_write <= 1'b1;
        @(posedge clk_sys);
        pwm_reg_write <= 1'b0;
        tick(3);
        chk(pwm_write_ok_q, 0, "relocked");
        $display("test pwm_lock done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys);
            fetch_valid <= 1'b1;
            fetch_addr <= fa[i];
            @(posedge clk_sys);
            fetch_valid <= 1'b0;
            #1 chk(fetch_reset_req_q, i < 3, "fetch");
        end
        $display("test fetch done");
        u_flash.mem[F_BOOT] = 24'hfffffe;
        prog(24'h000000, 0);
        prog(F_PART_B_OFS, 1);
        u_flash.mem[F_SEQ] = {~12'h005, 12'h005};
        u_flash.mem[F_SEQ+F_PART_B_OFS] = {~12'h003, 12'h003};
        do_reset(3);
        chk(active_partition_q, 1, "lower seq");
        chk_cfg(1, 1'b0);
        swap_pulse();
        chk(active_partition_q, 1, "swap disabled");
        u_flash.mem[F_SEQ + F_PART_B_OFS] = {12'h000, 12'h003};
        do_reset(3);
        chk(active_partition_q, 0, "bad inverse");
        chk_cfg(0, 1'b0);
        swap_pulse();
        chk(active_partition_q, 1, "soft swap");
        chk_cfg(0, 1'b0);
        $display("test dual_partition done");
        complete_run();
    end
endmodule
`default_nettype wire
